// ### hdl/eeprom_map.vh
// Purpose: Constants for the serial EEPROM slave front end
// Assumes: 125 MHz system clock
// Notes: Offsets, codes and timing counts live here
`ifndef EEPROM_MAP_VH
`define EEPROM_MAP_VH
`define CLOCK_MHZ 125
`define INTERNAL_WRITE_TIME_US 5000
`define INTERNAL_WRITE_CYCLES (`INTERNAL_WRITE_TIME_US * `CLOCK_MHZ)
`define MEM_BYTES 16384
`define ADDR_BITS 14
`define OFFSET_BITS 6
`define PAGE_BYTES 64
`define ERASED_BYTE 8'hFF
`define ADDR_RESET 14'h0000
`define BIT_LAST 3'h7
`endif

// ### hdl/byte_fifo.v
// Purpose: Small valid/ready FIFO for bytes moving toward the page buffer
// Assumes: Single clock, synchronous active-high reset
// Notes: Depth must be a power of two
`timescale 1ns/1ns
`default_nettype none
module byte_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 4,
   parameter AW = 2
) (
   // Clock and reset
   input wire clock,
   input wire rst,
   // Fill side
   input wire in_valid,
   input wire [WIDTH-1:0] in_data,
   output wire in_ready,
   // Drain side
   output wire out_valid,
   output wire [WIDTH-1:0] out_data,
   input wire out_ready
);
   localparam [AW:0] FULL = DEPTH;
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wr_ptr;
   reg [AW:0] rd_ptr;
   wire [AW:0] used = wr_ptr - rd_ptr;
   assign in_ready = (used != FULL);
   assign out_valid = (used != {(AW+1){1'b0}});
   assign out_data = mem[rd_ptr[AW-1:0]];
   always @(posedge clock)
   begin
      if (rst)
      begin
         wr_ptr <= {(AW+1){1'b0}};
         rd_ptr <= {(AW+1){1'b0}};
      end
      else
      begin
         if (in_valid && in_ready)
         begin
            mem[wr_ptr[AW-1:0]] <= in_data;
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (out_valid && out_ready)
            rd_ptr <= rd_ptr + 1'b1;
      end
   end
endmodule
`default_nettype wire

// ### hdl/eeprom_slave.v
// Purpose: Serial EEPROM slave: START/STOP, select, page write, reads
// Assumes: Serial clock sampled by the 125 MHz clock; pins synchronised here
// Notes: Write cycle length is a parameter so a bench can shorten it
// How it works
// - Power-on reset forces standby
// - Data pin driven open-drain only
// - Sample on clock rise, change on fall
// - START begins, STOP ends every command
// - Ignore bus until START seen
// - Select byte: type code plus strap bits
// - Select last bit: one read, zero write
// - Acknowledge select and address bytes; data bytes only with protect low
// - Release in ninth clock; send while acknowledged
// - Two address bytes: high and low, 14 bits used
// - Bytes to page buffer; STOP commits them
// - Write cycle: line released, requests ignored
// - No select acknowledge while write busy
// - Up to 64 bytes per write cycle
// - Offset wraps in page; latest data committed
// - Protect pin sampled before first data byte
// - Protect pin low allows normal writes
// - Read select sends byte at counter
// - Selective read loads counter from address
// - Sequential read wraps at memory end
// - Write cycle ends within 5 ms
`timescale 1ns/1ns
`default_nettype none
`include "eeprom_map.vh"
module eeprom_slave #(
   parameter [3:0] TYPE_CODE = 4'h5, // Arbitrary value
   parameter WRITE_CYCLES = `INTERNAL_WRITE_CYCLES
) (
   // Clock and power-on reset
   input wire clock,
   input wire rst,
   // Bus pins
   input wire scl_in,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe_n,
   // Straps
   input wire select_strap_bit0,
   input wire select_strap_bit1,
   input wire select_strap_bit2,
   input wire write_protect,
   // Status
   output reg write_busy
);
   localparam S_IDLE = 7'h01;
   localparam S_RECV = 7'h02;
   localparam S_ACK = 7'h04;
   localparam S_SEND = 7'h08;
   localparam S_MACK = 7'h10;
   localparam S_WAIT = 7'h20;
   localparam S_SKIP = 7'h40;
   localparam [1:0] P_SEL = 2'h0;
   localparam [1:0] P_AHI = 2'h1;
   localparam [1:0] P_ALO = 2'h2;
   localparam [1:0] P_DAT = 2'h3;
   reg [7:0] mem [0:`MEM_BYTES-1];
   reg [7:0] page_buf [0:`PAGE_BYTES-1];
   reg [`PAGE_BYTES-1:0] page_dirty;
   reg [2:0] scl_s;
   reg [2:0] sda_s;
   reg [1:0] wp_s;
   reg [6:0] state;
   reg [1:0] phase;
   reg [2:0] bit_cnt;
   reg [7:0] shreg;
   reg [`ADDR_BITS-1:0] addr;
   reg [7:0] addr_hi;
   reg ack_ok;
   reg wp_lock;
   reg commit;
   reg [`OFFSET_BITS:0] commit_idx;
   reg [31:0] busy_cnt;
   reg mem_init;
   reg [`ADDR_BITS-1:0] init_idx;
   // Two flops before any logic reads the pins; the third gives the edge
   wire scl = scl_s[1];
   wire sda = sda_s[1];
   wire scl_rise = scl_s[1] && !scl_s[2];
   wire scl_fall = !scl_s[1] && scl_s[2];
   wire start_cond = scl && scl_s[2] && !sda && sda_s[2];
   wire stop_cond = scl && scl_s[2] && sda && !sda_s[2];
   wire [2:0] straps = {select_strap_bit2, select_strap_bit1, select_strap_bit0};
   wire [7:0] rx_byte = {shreg[6:0], sda};
   wire sel_match = (rx_byte[7:4] == TYPE_CODE) && (rx_byte[3:1] == straps);
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [7:0] fifo_out_data;
   wire [`OFFSET_BITS-1:0] page_off = addr[`OFFSET_BITS-1:0];
   wire data_push = (state == S_RECV) && scl_rise && (bit_cnt == `BIT_LAST)
      && (phase == P_DAT) && !wp_lock && fifo_in_ready;
   always @(posedge clock)
   begin
      scl_s <= {scl_s[1:0], scl_in};
      sda_s <= {sda_s[1:0], sda_in};
      wp_s <= {wp_s[0], write_protect};
   end
   // Bytes pass a FIFO before the page buffer, which drains one per clock
   byte_fifo #(.WIDTH(8), .DEPTH(4), .AW(2)) u_fifo (
      .clock(clock),
      .rst(rst),
      .in_valid(data_push),
      .in_data(rx_byte),
      .in_ready(fifo_in_ready),
      .out_valid(fifo_out_valid),
      .out_data(fifo_out_data),
      .out_ready(1'b1)
   );
   always @(posedge clock)
   begin
      if (rst)
      begin
         state <= S_IDLE;
         phase <= P_SEL;
         bit_cnt <= 3'h0;
         shreg <= 8'h00;
         addr <= `ADDR_RESET;
         addr_hi <= 8'h00;
         ack_ok <= 1'b0;
         wp_lock <= 1'b0;
         commit <= 1'b0;
         commit_idx <= {(`OFFSET_BITS+1){1'b0}};
         busy_cnt <= 32'h0;
         write_busy <= 1'b0;
         page_dirty <= {`PAGE_BYTES{1'b0}};
         sda_out <= 1'b0;
         sda_oe_n <= 1'b1;
         mem_init <= 1'b1;
         init_idx <= `ADDR_RESET;
      end
      else
      begin
         if (mem_init)
         begin
            mem[init_idx] <= `ERASED_BYTE;
            init_idx <= init_idx + 1'b1;
            if (init_idx == `MEM_BYTES - 1)
               mem_init <= 1'b0;
         end
         else if (commit)
         begin
            // Only bytes loaded in this sequence reach the array
            if (page_dirty[commit_idx[`OFFSET_BITS-1:0]])
               mem[{addr[`ADDR_BITS-1:`OFFSET_BITS], commit_idx[`OFFSET_BITS-1:0]}]
                  <= page_buf[commit_idx[`OFFSET_BITS-1:0]];
            commit_idx <= commit_idx + 1'b1;
            if (commit_idx == `PAGE_BYTES - 1)
               commit <= 1'b0;
         end
         if (fifo_out_valid)
         begin
            page_buf[page_off] <= fifo_out_data;
            page_dirty[page_off] <= 1'b1;
            addr[`OFFSET_BITS-1:0] <= page_off + 1'b1;
         end
         if (write_busy)
         begin
            // Counter ends the cycle no later than the 5 ms bound
            if (busy_cnt >= WRITE_CYCLES - 1)
               write_busy <= 1'b0;
            busy_cnt <= busy_cnt + 1'b1;
         end
         if (stop_cond)
         begin
            sda_oe_n <= 1'b1;
            if (phase == P_DAT && page_dirty != {`PAGE_BYTES{1'b0}} && !write_busy)
            begin
               commit <= 1'b1;
               commit_idx <= {(`OFFSET_BITS+1){1'b0}};
               write_busy <= 1'b1;
               busy_cnt <= 32'h0;
            end
            state <= S_IDLE;
            phase <= P_SEL;
         end
         else if (start_cond)
         begin
            sda_oe_n <= 1'b1;
            state <= S_RECV;
            phase <= P_SEL;
            bit_cnt <= 3'h0;
            // A polling START must not wipe bytes still being committed
            if (!commit)
               page_dirty <= {`PAGE_BYTES{1'b0}};
         end
         else
         begin
            case (state)
               S_RECV:
               begin
                  if (scl_rise)
                  begin
                     shreg <= rx_byte;
                     bit_cnt <= bit_cnt + 1'b1;
                     if (bit_cnt == `BIT_LAST)
                     begin
                        state <= S_ACK;
                        ack_ok <= 1'b1;
                        case (phase)
                           P_SEL:
                           begin
                              if (!sel_match || write_busy)
                              begin
                                 ack_ok <= 1'b0;
                                 state <= S_SKIP;
                              end
                           end
                           P_AHI:
                              addr_hi <= rx_byte;
                           P_ALO:
                           begin
                              addr <= {addr_hi[5:0], rx_byte};
                              page_dirty <= {`PAGE_BYTES{1'b0}};
                           end
                           default:
                              ack_ok <= !wp_lock;
                        endcase
                     end
                  end
               end
               S_ACK:
               begin
                  if (scl_fall)
                  begin
                     if (ack_ok)
                     begin
                        sda_out <= 1'b0;
                        sda_oe_n <= 1'b0;
                     end
                     state <= S_WAIT;
                  end
               end
               S_WAIT:
               begin
                  // Ninth clock: release on its falling edge
                  if (scl_fall)
                  begin
                     sda_oe_n <= 1'b1;
                     bit_cnt <= 3'h0;
                     state <= S_RECV;
                     if (phase == P_SEL)
                     begin
                        if (shreg[0])
                        begin
                           shreg <= mem[addr];
                           state <= S_SEND;
                           sda_out <= 1'b0;
                           sda_oe_n <= mem[addr][7];
                        end
                        else
                           phase <= P_AHI;
                     end
                     else if (phase == P_AHI)
                        phase <= P_ALO;
                     else if (phase == P_ALO)
                     begin
                        phase <= P_DAT;
                        wp_lock <= wp_s[1];
                     end
                     if (!ack_ok)
                        state <= S_SKIP;
                  end
               end
               S_SEND:
               begin
                  if (scl_fall)
                  begin
                     bit_cnt <= bit_cnt + 1'b1;
                     shreg <= {shreg[6:0], 1'b0};
                     sda_oe_n <= shreg[6];
                     if (bit_cnt == `BIT_LAST)
                     begin
                        sda_oe_n <= 1'b1;
                        addr <= addr + 1'b1;
                        state <= S_MACK;
                     end
                  end
               end
               S_MACK:
               begin
                  if (scl_rise)
                     ack_ok <= !sda;
                  if (scl_fall)
                  begin
                     bit_cnt <= 3'h0;
                     if (ack_ok)
                     begin
                        shreg <= mem[addr];
                        sda_oe_n <= mem[addr][7];
                        state <= S_SEND;
                     end
                     else
                        state <= S_SKIP;
                  end
               end
               default:
                  sda_oe_n <= 1'b1;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ### tb/eeprom_slave_props.sv
// Purpose: Timing checks on the EEPROM slave pins
// Assumes: Bus clock half period of four system clocks
// Notes: Attached by bind below
`timescale 1ns/1ns
`default_nettype none
module eeprom_slave_props #(
   parameter WRITE_CYCLES = 625000
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   // Status
   input wire logic write_busy
);
   logic [31:0] busy_cnt;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   // A stuck write cycle would otherwise hang polling forever
   always_ff @(posedge clock)
      if (rst || !write_busy)
         busy_cnt <= 32'h0;
      else
         busy_cnt <= busy_cnt + 32'h1;
   a_busy_released: assert property (write_busy |-> sda_oe_n)
      else $error("line pulled during write cycle");
   a_open_drain: assert property (!sda_oe_n |-> sda_out == 1'b0)
      else $error("line driven high");
   a_reset_quiet: assert property (disable iff (1'b0) rst |=> sda_oe_n && !write_busy)
      else $error("reset left device active");
   a_busy_bound: assert property (busy_cnt <= WRITE_CYCLES)
      else $error("write cycle too long");
   a_change_low: assert property ($changed(sda_oe_n) |-> !scl_in)
      else $error("output changed with clock high");
   a_high_stable: assert property ($rose(scl_in) |=> $stable(sda_oe_n)[*3])
      else $error("output moved during clock high");
   a_busy_after_stop: assert property ($rose(write_busy) |-> scl_in && sda_in)
      else $error("write cycle began outside idle bus");
   a_pull_holds: assert property ($fell(sda_oe_n) |-> !sda_oe_n[*8])
      else $error("pull shorter than one bit");
endmodule
bind eeprom_slave eeprom_slave_props #(.WRITE_CYCLES(WRITE_CYCLES)) props (.clock(clock),
   .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
   .write_busy(write_busy));
`default_nettype wire

// ### tb/bus_master_model.sv
// Purpose: Bus master driving clock and data for the slave
// Assumes: Clock period 64 ns, eight system clocks
// Notes: Clock stands high between frames
`timescale 1ns/1ns
`default_nettype none
module bus_master_model (
   // System clock
   input wire logic clock,
   // Bus
   input wire logic sda,
   output logic scl,
   output logic sda_m
);
   initial
   begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   task automatic set(input logic c, input logic d, input int n);
      sda_m = d;
      scl = c;
      repeat (n) @(negedge clock);
   endtask
   // Data moves only while clock is low
   task automatic bit_x(input logic d, output logic s);
      set(1'b0, sda_m, 2);
      set(1'b0, d, 2);
      set(1'b1, d, 3);
      s = sda;
      repeat (1) @(negedge clock);
   endtask
   task automatic start_c();
      set(1'b0, sda_m, 2);
      set(1'b0, 1'b1, 2);
      set(1'b1, 1'b1, 2);
      set(1'b1, 1'b0, 2);
   endtask
   task automatic stop_c();
      set(1'b0, sda_m, 2);
      set(1'b0, 1'b0, 2);
      set(1'b1, 1'b0, 2);
      set(1'b1, 1'b1, 4);
   endtask
   task automatic put(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_x(b[i], s);
      bit_x(1'b1, ack);
   endtask
   task automatic get(input logic a, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bit_x(1'b1, s);
         b[i] = s;
      end
      bit_x(a, s);
   endtask
endmodule
`default_nettype wire

// ### tb/eeprom_slave_tb.sv
// Purpose: Self-checking bench for the EEPROM slave
// Assumes: Write cycle shortened to 200 clocks
// Notes: Straps fixed at 101
`timescale 1ns/1ns
`default_nettype none
module eeprom_slave_tb;
   localparam int WC = 200;
   logic clock, rst, scl, sda_m, sda_out, sda_oe_n, write_protect, write_busy, a;
   logic [7:0] d;
   int err_total = 0;
   int checked = 0;
   wire sda = sda_m & (sda_oe_n | sda_out);
   // Type code value is arbitrary
   eeprom_slave #(.TYPE_CODE(4'h5), .WRITE_CYCLES(WC)) DUT (.clock(clock), .rst(rst),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
      .select_strap_bit0(1'b1), .select_strap_bit1(1'b0), .select_strap_bit2(1'b1),
      .write_protect(write_protect), .write_busy(write_busy));
   bus_master_model m (.clock(clock), .sda(sda), .scl(scl), .sda_m(sda_m));
   task automatic close_out();
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Top two address bits set to show they are ignored
   task automatic addr_w(input logic [13:0] ad);
      m.start_c();
      m.put(8'h5A, a);
      chk({7'h00, a}, 8'h00);
      m.put({2'b11, ad[13:8]}, a);
      chk({7'h00, a}, 8'h00);
      m.put(ad[7:0], a);
      chk({7'h00, a}, 8'h00);
   endtask
   task automatic rd(input logic [13:0] ad, input int n, input logic [7:0] e[3]);
      addr_w(ad);
      m.start_c();
      m.put(8'h5B, a);
      chk({7'h00, a}, 8'h00);
      for (int i = 0; i < n; i++)
      begin
         m.get(i == n - 1, d);
         chk(d, e[i]);
      end
      m.stop_c();
   endtask
   task automatic wait_idle();
      repeat (8) @(negedge clock);
      for (int i = 0; i < WC + 50 && write_busy !== 1'b0; i++)
         @(negedge clock);
      chk({7'h00, write_busy}, 8'h00);
   endtask
   task automatic t_blank();
      m.start_c();
      m.put(8'h5B, a);
      chk({7'h00, a}, 8'h00);
      m.get(1'b1, d);
      chk(d, 8'hFF);
      m.stop_c();
      m.start_c();
      m.put(8'h58, a);
      chk({7'h00, a}, 8'h01);
      m.put(8'h00, a);
      chk({7'h00, a}, 8'h01);
      m.stop_c();
      m.put(8'h5A, a);
      chk({7'h00, a}, 8'h01);
      m.stop_c();
      $display("test blank done");
   endtask
   // 66 bytes from offset 62: wraps in page, last two overwrite first two
   task automatic t_page();
      addr_w(14'h003E);
      for (int i = 0; i < 66; i++)
      begin
         m.put(8'(i), a);
         chk({7'h00, a}, 8'h00);
      end
      m.stop_c();
      repeat (8) @(negedge clock);
      chk({7'h00, write_busy}, 8'h01);
      m.start_c();
      m.put(8'h5A, a);
      chk({7'h00, a}, 8'h01);
      m.stop_c();
      wait_idle();
      rd(14'h003E, 3, '{8'h40, 8'h41, 8'hFF});
      rd(14'h3FFF, 2, '{8'hFF, 8'h02, 8'h00});
      $display("test page done");
   endtask
   task automatic t_protect();
      write_protect = 1'b1;
      addr_w(14'h0105);
      m.put(8'h33, a);
      chk({7'h00, a}, 8'h01);
      m.stop_c();
      repeat (20) @(negedge clock);
      chk({7'h00, write_busy}, 8'h00);
      write_protect = 1'b0;
      rd(14'h0105, 1, '{8'hFF, 8'h00, 8'h00});
      addr_w(14'h0105);
      m.put(8'h33, a);
      chk({7'h00, a}, 8'h00);
      m.stop_c();
      wait_idle();
      rd(14'h0105, 1, '{8'h33, 8'h00, 8'h00});
      $display("test protect done");
   endtask
   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   initial
   begin
      repeat (60000) @(posedge clock);
      err_total++;
      close_out();
   end
   initial
   begin
      rst = 1'b1;
      write_protect = 1'b0;
      repeat (6) @(negedge clock);
      rst = 1'b0;
      // Array clears after reset before traffic is allowed
      repeat (16500) @(negedge clock);
      t_blank();
      t_page();
      t_protect();
      close_out();
   end
endmodule
`default_nettype wire
